// ### scbd_control.sv
`default_nettype none
module scbd_control
  import scbd_pkg::*;
(
  input  wire  logic                       sys_clk,
  input  wire  logic                       rst,
  input  wire  logic [scbd_pkg::ADDR_W-1:0] regAddr,
  input  wire  logic [scbd_pkg::DATA_W-1:0] regWrData,
  input  wire  logic                       regWr,
  input  wire  logic                       regRd,
  output logic [scbd_pkg::DATA_W-1:0]      regRdData,
  input  wire  logic [scbd_pkg::CH_W-1:0]   lineCh,
  input  wire  logic                       rxClose,
  input  wire  logic                       rxCrcErr,
  input  wire  logic                       rxOverrun,
  input  wire  logic                       rxCarrierLost,
  input  wire  logic [scbd_pkg::DATA_W-1:0] rxByteCount,
  input  wire  logic                       txClose,
  input  wire  logic                       txUnderrun,
  input  wire  logic                       txCtsLost,
  input  wire  logic [scbd_pkg::NCH-1:0]    timerInputPin,
  input  wire  logic [scbd_pkg::NCH-1:0]    txClockPin,
  input  wire  logic [scbd_pkg::NCH-1:0]    txDataIn,
  input  wire  logic                       layer1TxIn,
  input  wire  logic                       layer1RxIn,
  output logic [scbd_pkg::NCH-1:0]         txReady,
  output logic [scbd_pkg::NCH-1:0]         txExtBuf,
  output logic [scbd_pkg::NCH-1:0]         rxEmpty,
  output logic [scbd_pkg::NCH-1:0]         rxExtBuf,
  output logic [scbd_pkg::NCH-1:0]         rxEvent,
  output logic [scbd_pkg::NCH-1:0]         huntPulse,
  output logic [scbd_pkg::NCH-1:0]         bcsResetPulse,
  output logic [scbd_pkg::NCH-1:0]         txClkOut,
  output logic [scbd_pkg::NCH-1:0]         rxClkOut,
  output logic [scbd_pkg::NCH-1:0]         txdOut,
  output logic [scbd_pkg::NCH-1:0]         txdOe,
  output logic                             layer1TxOut,
  output logic                             layer1RxToChan,
  output logic                             syncStyle
);
  import scbd_pkg::*;

  function automatic logic [BD_IDX_W-1:0] bdIdx(input logic [CH_W-1:0] ch, input logic dir,
                                                input logic [BD_N_W-1:0] n, input logic [1:0] w);
    bdIdx = {ch, dir, n, w};
  endfunction : bdIdx

  function automatic logic [BD_N_W-1:0] bdNext(input logic [BD_N_W-1:0] n, input logic wrap);
    bdNext = wrap ? '0 : BD_N_W'(n + 1'b1);
  endfunction : bdNext

  // per-channel register hit: returns channel or CH_RESERVED
  function automatic logic [CH_W-1:0] chHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    chHit = CH_RESERVED;
    for (int c = 0; c < NCH; c++) begin
      if (a == ADDR_W'(base + ADDR_W'(c) * CH_STRIDE)) begin
        chHit = CH_W'(c);
      end
    end
  endfunction : chHit

  typedef enum {CMD_IDLE, CMD_RUN} scbd_cmd_e;

  logic [DATA_W-1:0] bdMem [BD_DEPTH];
  logic [DATA_W-1:0] clkCfg_q [NCH];
  logic [DATA_W-1:0] clkCfg_d [NCH];
  logic [DATA_W-1:0] modeCfg_q [NCH];
  logic [DATA_W-1:0] modeCfg_d [NCH];
  logic [DATA_W-1:0] serial_interface_mode_q, serial_interface_mode_d;
  logic [7:0]        cmdReg_q, cmdReg_d;
  scbd_cmd_e         cmdState_q, cmdState_d;
  logic [2:0]        cmdCnt_q, cmdCnt_d;
  logic [NCH-1:0]    txStopped_q, txStopped_d;
  logic [NCH-1:0]    rxEvent_q, rxEvent_d;
  logic [NCH-1:0]    hunt_q, hunt_d, bcs_q, bcs_d;
  logic [BD_N_W-1:0] txIdx_q [NCH];
  logic [BD_N_W-1:0] txIdx_d [NCH];
  logic [BD_N_W-1:0] rxIdx_q [NCH];
  logic [BD_N_W-1:0] rxIdx_d [NCH];
  logic [DATA_W-1:0] rdData_q, rdData_d;

  // line-side closes wait here while the bus owns the descriptor port
  logic              rxPend_q, rxPend_d, txPend_q, txPend_d;
  logic [CH_W-1:0]   rxCh_q, rxCh_d, txCh_q, txCh_d;
  logic [2:0]        rxSt_q, rxSt_d;
  logic [1:0]        txSt_q, txSt_d;
  logic [DATA_W-1:0] rxLen_q, rxLen_d;

  logic              bdBusWr, rxDo, txDo;
  logic [BD_IDX_W-1:0] rxW0, txW0;
  logic [DATA_W-1:0] rxWord, txWord, rxNew, txNew;

  // bus write to descriptors has priority; receive closes before transmit
  always_comb begin
    bdBusWr = regWr && (regAddr[ADDR_W-1:ADDR_W-3] == BD_REGION);
    rxDo    = rxPend_q && !bdBusWr;
    txDo    = txPend_q && !bdBusWr && !rxDo;
    rxW0    = bdIdx(rxCh_q, DIR_RX, rxIdx_q[rxCh_q], BD_W_CTRL);
    txW0    = bdIdx(txCh_q, DIR_TX, txIdx_q[txCh_q], BD_W_CTRL);
    rxWord  = bdMem[rxW0];
    txWord  = bdMem[txW0];
    rxNew   = rxWord;
    rxNew[BD_READY]   = 1'b0;
    rxNew[BD_CRC]     = rxSt_q[BD_CRC];
    rxNew[BD_OVERRUN] = rxSt_q[BD_OVERRUN];
    rxNew[BD_CDLOST]  = rxSt_q[BD_CDLOST];
    txNew   = txWord;
    txNew[BD_READY]    = 1'b0;
    txNew[BD_UNDERRUN] = txSt_q[BD_UNDERRUN];
    txNew[BD_CTSLOST]  = txSt_q[BD_CTSLOST];
  end

  // descriptor memory: 4 channel slots (3 channels + reserved) x (8 rx + 8 tx) x 4 words
  always_ff @(posedge sys_clk) begin
    if (bdBusWr) begin
      bdMem[regAddr[BD_IDX_W:1]] <= regWrData;
    end else if (rxDo) begin
      bdMem[rxW0] <= rxNew;
      bdMem[BD_IDX_W'(rxW0 + BD_IDX_W'(BD_W_LEN))] <= rxLen_q;
    end else if (txDo) begin
      bdMem[txW0] <= txNew;
    end
  end

  always_comb begin
    rxPend_d  = rxPend_q;
    rxCh_d    = rxCh_q;
    rxSt_d    = rxSt_q;
    rxLen_d   = rxLen_q;
    txPend_d  = txPend_q;
    txCh_d    = txCh_q;
    txSt_d    = txSt_q;
    rxEvent_d = rxEvent_q;
    rxIdx_d   = rxIdx_q;
    txIdx_d   = txIdx_q;
    // clear first, so a close in the same cycle wins
    if (regWr && chHit(regAddr, EVENT_BASE) != CH_RESERVED && regWrData[0]) begin
      rxEvent_d[chHit(regAddr, EVENT_BASE)] = 1'b0;
    end
    if (rxDo) begin
      rxPend_d = 1'b0;
      if (rxWord[BD_INT]) begin
        rxEvent_d[rxCh_q] = 1'b1;
      end
      rxIdx_d[rxCh_q] = bdNext(rxIdx_q[rxCh_q], rxWord[BD_WRAP]);
    end
    if (txDo) begin
      txPend_d = 1'b0;
      txIdx_d[txCh_q] = bdNext(txIdx_q[txCh_q], txWord[BD_WRAP]);
    end
    // a close on a reserved channel or a non-owned descriptor is dropped
    if (rxClose && lineCh != CH_RESERVED && rxEmpty[lineCh] && !(rxPend_q && !rxDo)) begin
      rxPend_d = 1'b1;
      rxCh_d   = lineCh;
      rxSt_d   = {rxCrcErr, rxOverrun, rxCarrierLost && modeCfg_q[lineCh][DATA_W-1]};
      rxLen_d  = rxByteCount;
    end
    if (txClose && lineCh != CH_RESERVED && txReady[lineCh] && !(txPend_q && !txDo)) begin
      txPend_d = 1'b1;
      txCh_d   = lineCh;
      txSt_d   = {txUnderrun, txCtsLost};
    end
  end

  // register writes
  always_comb begin
    clkCfg_d  = clkCfg_q;
    modeCfg_d = modeCfg_q;
    serial_interface_mode_d  = serial_interface_mode_q;
    if (regWr) begin
      if (chHit(regAddr, CLK_CFG_BASE) != CH_RESERVED) begin
        clkCfg_d[chHit(regAddr, CLK_CFG_BASE)] = regWrData;
      end
      if (chHit(regAddr, MODE_CFG_BASE) != CH_RESERVED) begin
        modeCfg_d[chHit(regAddr, MODE_CFG_BASE)] = regWrData;
      end
      if (regAddr == SERIAL_INTERFACE_MODE_ADDR) begin
        serial_interface_mode_d = regWrData;
      end
    end
  end

  // command processor: flag stays up for the whole execution
  always_comb begin
    cmdReg_d    = cmdReg_q;
    cmdState_d  = cmdState_q;
    cmdCnt_d    = cmdCnt_q;
    txStopped_d = txStopped_q;
    hunt_d      = '0;
    bcs_d       = '0;
    unique case (cmdState_q)
      CMD_IDLE: begin
        if (regWr && regAddr == CMD_ADDR) begin
          cmdReg_d = regWrData[7:0];
          if (regWrData[CMD_FLAG]) begin
            cmdState_d = CMD_RUN;
            cmdCnt_d   = CMD_EXEC_CYCLES;
          end
        end
      end
      CMD_RUN: begin
        cmdCnt_d = 3'(cmdCnt_q - 1'b1);
        if (cmdCnt_q == 3'h1) begin
          cmdState_d         = CMD_IDLE;
          cmdReg_d[CMD_FLAG] = 1'b0;
          if (cmdReg_q[CMD_CH_LO+:CH_W] != CH_RESERVED) begin
            unique case (scbd_op_e'(cmdReg_q[CMD_OP_LO+:2]))
              OP_STOP_TX:    txStopped_d[cmdReg_q[CMD_CH_LO+:CH_W]] = 1'b1;
              OP_RESTART_TX: txStopped_d[cmdReg_q[CMD_CH_LO+:CH_W]] = 1'b0;
              OP_HUNT:       hunt_d[cmdReg_q[CMD_CH_LO+:CH_W]] = 1'b1;
              OP_RESET_BCS: begin
                if (modeCfg_q[cmdReg_q[CMD_CH_LO+:CH_W]][1:0] == MODE_BISYNC) begin
                  bcs_d[cmdReg_q[CMD_CH_LO+:CH_W]] = 1'b1;
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  // read data stands in the cycle after the strobe only
  always_comb begin
    rdData_d = '0;
    if (regRd) begin
      if (regAddr[ADDR_W-1:ADDR_W-3] == BD_REGION) begin
        rdData_d = bdMem[regAddr[BD_IDX_W:1]];
      end else if (chHit(regAddr, CLK_CFG_BASE) != CH_RESERVED) begin
        rdData_d = clkCfg_q[chHit(regAddr, CLK_CFG_BASE)];
      end else if (chHit(regAddr, MODE_CFG_BASE) != CH_RESERVED) begin
        rdData_d = modeCfg_q[chHit(regAddr, MODE_CFG_BASE)];
      end else if (chHit(regAddr, EVENT_BASE) != CH_RESERVED) begin
        rdData_d = DATA_W'(rxEvent_q[chHit(regAddr, EVENT_BASE)]);
      end else if (regAddr == SERIAL_INTERFACE_MODE_ADDR) begin
        rdData_d = serial_interface_mode_q;
      end else if (regAddr == CMD_ADDR) begin
        rdData_d = DATA_W'(cmdReg_q);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkCfg_q    <= '{default: '0};
      modeCfg_q   <= '{default: '0};
      serial_interface_mode_q    <= '0;
      cmdReg_q    <= '0;
      cmdState_q  <= CMD_IDLE;
      cmdCnt_q    <= '0;
      txStopped_q <= '0;
      rxEvent_q   <= '0;
      hunt_q      <= '0;
      bcs_q       <= '0;
      txIdx_q     <= '{default: '0};
      rxIdx_q     <= '{default: '0};
      rdData_q    <= '0;
      rxPend_q    <= 1'b0;
      rxCh_q      <= '0;
      rxSt_q      <= '0;
      rxLen_q     <= '0;
      txPend_q    <= 1'b0;
      txCh_q      <= '0;
      txSt_q      <= '0;
    end else begin
      clkCfg_q    <= clkCfg_d;
      modeCfg_q   <= modeCfg_d;
      serial_interface_mode_q    <= serial_interface_mode_d;
      cmdReg_q    <= cmdReg_d;
      cmdState_q  <= cmdState_d;
      cmdCnt_q    <= cmdCnt_d;
      txStopped_q <= txStopped_d;
      rxEvent_q   <= rxEvent_d;
      hunt_q      <= hunt_d;
      bcs_q       <= bcs_d;
      txIdx_q     <= txIdx_d;
      rxIdx_q     <= rxIdx_d;
      rdData_q    <= rdData_d;
      rxPend_q    <= rxPend_d;
      rxCh_q      <= rxCh_d;
      rxSt_q      <= rxSt_d;
      rxLen_q     <= rxLen_d;
      txPend_q    <= txPend_d;
      txCh_q      <= txCh_d;
      txSt_q      <= txSt_d;
    end
  end

  // baud generators, one per channel
  logic [1:0]       presc_q [NCH];
  logic [1:0]       presc_d [NCH];
  logic [DIV_W-1:0] baudCnt_q [NCH];
  logic [DIV_W-1:0] baudCnt_d [NCH];
  logic [NCH-1:0]   brgOut_q, brgOut_d, timerLast_q;
  logic [NCH-1:0]   txRdy_d, txExt_d, rxEmp_d, rxExt_d, txClk_d, rxClk_d, txdOut_d, txdOe_d;
  logic             l1Tx_d, l1Rx_d;
  logic [DATA_W-1:0] curTx, curRx;
  logic             srcTick, prTick;

  always_comb begin
    presc_d   = presc_q;
    baudCnt_d = baudCnt_q;
    brgOut_d  = brgOut_q;
    txRdy_d   = '0;
    txExt_d   = '0;
    rxEmp_d   = '0;
    rxExt_d   = '0;
    txClk_d   = '0;
    rxClk_d   = '0;
    txdOut_d  = '0;
    txdOe_d   = '0;
    curTx     = '0;
    curRx     = '0;
    srcTick   = 1'b0;
    prTick    = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      // timer pin edge vs main clock, trading a gate for a clock mux
      srcTick = clkCfg_q[c][CC_EXT_SRC] ? (timerInputPin[c] && !timerLast_q[c]) : 1'b1;
      prTick  = 1'b0;
      if (srcTick) begin
        presc_d[c] = clkCfg_q[c][CC_PRESCALE] ? 2'(presc_q[c] + 1'b1) : '0;
        prTick = !clkCfg_q[c][CC_PRESCALE] || presc_q[c] == PRESCALE_LAST;
      end
      if (prTick) begin
        if (baudCnt_q[c] == '0) begin
          baudCnt_d[c] = clkCfg_q[c][CC_DIV_LO+:DIV_W];
          brgOut_d[c]  = !brgOut_q[c];
        end else begin
          baudCnt_d[c] = DIV_W'(baudCnt_q[c] - 1'b1);
        end
      end
      txClk_d[c] = clkCfg_q[c][CC_TX_CLK_SEL] ? txClockPin[c] : brgOut_q[c];
      rxClk_d[c] = clkCfg_q[c][CC_RX_CLK_SEL] ? txClockPin[c] : brgOut_q[c];
      // open drain only ever pulls low
      txdOut_d[c] = clkCfg_q[c][CC_OPEN_DRAIN] ? 1'b0 : txDataIn[c];
      txdOe_d[c]  = clkCfg_q[c][CC_OPEN_DRAIN] ? !txDataIn[c] : 1'b1;
      curTx = bdMem[bdIdx(CH_W'(c), DIR_TX, txIdx_q[c], BD_W_CTRL)];
      curRx = bdMem[bdIdx(CH_W'(c), DIR_RX, rxIdx_q[c], BD_W_CTRL)];
      // a pending close still owns the descriptor until written back
      txRdy_d[c] = curTx[BD_READY] && !txStopped_q[c] && !(txPend_q && txCh_q == CH_W'(c));
      txExt_d[c] = curTx[BD_EXT];
      rxEmp_d[c] = curRx[BD_READY] && !(rxPend_q && rxCh_q == CH_W'(c));
      rxExt_d[c] = curRx[BD_EXT];
    end
    unique case (scbd_diag_e'(serial_interface_mode_q[SI_DIAG_LO+:2]))
      DIAG_NORMAL:    begin l1Tx_d = layer1TxIn; l1Rx_d = layer1RxIn; end
      DIAG_ECHO:      begin l1Tx_d = layer1RxIn; l1Rx_d = layer1RxIn; end
      DIAG_LOOP:      begin l1Tx_d = layer1TxIn; l1Rx_d = layer1TxIn; end
      DIAG_LOOP_CTRL: begin l1Tx_d = layer1TxIn; l1Rx_d = layer1TxIn; end
    endcase
    if (serial_interface_mode_q[SI_FORCE_ZERO]) begin
      l1Tx_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presc_q        <= '{default: '0};
      baudCnt_q      <= '{default: '0};
      brgOut_q       <= '0;
      timerLast_q    <= '0;
      txReady        <= '0;
      txExtBuf       <= '0;
      rxEmpty        <= '0;
      rxExtBuf       <= '0;
      txClkOut       <= '0;
      rxClkOut       <= '0;
      txdOut         <= '0;
      txdOe          <= '0;
      layer1TxOut    <= 1'b0;
      layer1RxToChan <= 1'b0;
      syncStyle      <= 1'b0;
    end else begin
      presc_q        <= presc_d;
      baudCnt_q      <= baudCnt_d;
      brgOut_q       <= brgOut_d;
      timerLast_q    <= timerInputPin;
      txReady        <= txRdy_d;
      txExtBuf       <= txExt_d;
      rxEmpty        <= rxEmp_d;
      rxExtBuf       <= rxExt_d;
      txClkOut       <= txClk_d;
      rxClkOut       <= rxClk_d;
      txdOut         <= txdOut_d;
      txdOe          <= txdOe_d;
      layer1TxOut    <= l1Tx_d;
      layer1RxToChan <= l1Rx_d;
      syncStyle      <= serial_interface_mode_q[SI_SYNC_STYLE];
    end
  end

  assign regRdData     = rdData_q;
  assign rxEvent       = rxEvent_q;
  assign huntPulse     = hunt_q;
  assign bcsResetPulse = bcs_q;
endmodule : scbd_control
`default_nettype wire

// ### scbd_pkg.sv
`default_nettype none
package scbd_pkg;
  localparam int NCH      = 3;
  localparam int CH_W     = 2;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int DIV_W    = 11;
  localparam int BD_N_W   = 3;
  localparam int BD_IDX_W = 8;
  localparam int BD_DEPTH = 256;

  localparam logic [ADDR_W-1:0] CLK_CFG_BASE  = 12'h882;
  localparam logic [ADDR_W-1:0] MODE_CFG_BASE = 12'h884;
  localparam logic [ADDR_W-1:0] EVENT_BASE    = 12'h888;
  localparam logic [ADDR_W-1:0] CH_STRIDE     = 12'h010;
  localparam logic [ADDR_W-1:0] SERIAL_INTERFACE_MODE_ADDR   = 12'h8b4;
  localparam logic [ADDR_W-1:0] CMD_ADDR      = 12'h860;
  localparam logic [2:0]        BD_REGION     = 3'b010;

  // command register layout
  localparam int CMD_FLAG  = 0;
  localparam int CMD_OP_LO = 1;
  localparam int CMD_CH_LO = 4;
  localparam logic [1:0] CH_RESERVED = 2'b11;
  localparam logic [2:0] CMD_EXEC_CYCLES = 3'h2;
  typedef enum logic [1:0] {OP_STOP_TX, OP_RESTART_TX, OP_HUNT, OP_RESET_BCS} scbd_op_e;

  // serial interface mode
  localparam int SI_FORCE_ZERO = 15;
  localparam int SI_SYNC_STYLE = 14;
  localparam int SI_DIAG_LO    = 12;
  typedef enum logic [1:0] {DIAG_NORMAL, DIAG_ECHO, DIAG_LOOP, DIAG_LOOP_CTRL} scbd_diag_e;

  // channel clock config
  localparam int CC_OPEN_DRAIN = 15;
  localparam int CC_EXT_SRC    = 14;
  localparam int CC_TX_CLK_SEL = 13;
  localparam int CC_RX_CLK_SEL = 12;
  localparam int CC_DIV_LO     = 1;
  localparam int CC_PRESCALE   = 0;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // channel mode config: low bits pick protocol
  localparam logic [1:0] MODE_BISYNC = 2'h2;

  // descriptor word 0
  localparam int BD_READY   = 15;
  localparam int BD_EXT     = 14;
  localparam int BD_WRAP    = 13;
  localparam int BD_INT     = 12;
  localparam int BD_CRC     = 2;
  localparam int BD_OVERRUN = 1;
  localparam int BD_CDLOST  = 0;
  localparam int BD_UNDERRUN = 1;
  localparam int BD_CTSLOST  = 0;
  localparam logic [1:0] BD_W_CTRL = 2'h0;
  localparam logic [1:0] BD_W_LEN  = 2'h1;
  localparam logic DIR_RX = 1'b0;
  localparam logic DIR_TX = 1'b1;
endpackage : scbd_pkg
`default_nettype wire

// ### scbd_control_chk.sv
`default_nettype none
module scbd_control_chk
  import scbd_pkg::*;
(
  input wire logic                        sys_clk,
  input wire logic                        rst,
  input wire logic [scbd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [scbd_pkg::DATA_W-1:0] regWrData,
  input wire logic                        regWr,
  input wire logic [scbd_pkg::CH_W-1:0]   lineCh,
  input wire logic                        rxClose,
  input wire logic [scbd_pkg::NCH-1:0]    rxEvent,
  input wire logic [scbd_pkg::NCH-1:0]    txReady,
  input wire logic [scbd_pkg::NCH-1:0]    huntPulse,
  input wire logic [scbd_pkg::NCH-1:0]    txDataIn,
  input wire logic [scbd_pkg::NCH-1:0]    txdOut,
  input wire logic [scbd_pkg::NCH-1:0]    txdOe,
  input wire logic [scbd_pkg::NCH-1:0]    txClockPin,
  input wire logic [scbd_pkg::NCH-1:0]    txClkOut,
  input wire logic                        layer1TxOut
);
  logic odSel_q, odSel_d, pinSel_q, pinSel_d, zero_q, zero_d;
  logic huntWr, stopWr, rxEnd;
  assign huntWr = regWr && regAddr == CMD_ADDR && regWrData[5:0] == 6'h05;
  assign stopWr = regWr && regAddr == CMD_ADDR && regWrData[5:0] == 6'h01;
  assign rxEnd  = rxClose && lineCh == 2'h0;
  // shadow of channel-0 and serial mode bits, taken on the same edge as the design
  always_comb begin
    odSel_d = odSel_q;
    pinSel_d = pinSel_q;
    zero_d = zero_q;
    if (regWr && regAddr == CLK_CFG_BASE) begin
      odSel_d = regWrData[CC_OPEN_DRAIN];
      pinSel_d = regWrData[CC_TX_CLK_SEL];
    end
    if (regWr && regAddr == SERIAL_INTERFACE_MODE_ADDR) zero_d = regWrData[SI_FORCE_ZERO];
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) {odSel_q, pinSel_q, zero_q} <= 3'h0;
    else {odSel_q, pinSel_q, zero_q} <= {odSel_d, pinSel_d, zero_d};
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // outputs are held low for one edge after reset, so data relations wait two
  AST_HUNT_CAUSE: assert property (huntPulse[0] |-> $past(huntWr, 3) || $past(huntWr, 4))
    else $error("hunt pulse without a hunt command");
  AST_HUNT_SINGLE: assert property (huntPulse[0] |=> !huntPulse[0])
    else $error("hunt pulse longer than one cycle");
  AST_STOP_READY: assert property (stopWr |-> ##5 !txReady[0])
    else $error("transmit still ready after stop");
  AST_ZERO_FORCE: assert property ($past(zero_q) |-> !layer1TxOut)
    else $error("layer-1 output not forced low");
  AST_TXD_OPEN_DRAIN: assert property (!$past(rst) && !$past(rst, 2) && $past(odSel_q)
    |-> !txdOut[0] && txdOe[0] == !$past(txDataIn[0]))
    else $error("open-drain driver wrong");
  AST_TXD_NORMAL: assert property (!$past(rst) && !$past(rst, 2) && !$past(odSel_q)
    |-> txdOe[0] && txdOut[0] == $past(txDataIn[0]))
    else $error("normal driver wrong");
  AST_TX_CLK_PIN: assert property (!$past(rst) && !$past(rst, 2) && $past(pinSel_q)
    |-> txClkOut[0] == $past(txClockPin[0]))
    else $error("transmit clock not taken from pin");
  AST_RX_EVENT_CAUSE: assert property ($rose(rxEvent[0]) |-> $past(rxEnd, 2) || $past(rxEnd, 3))
    else $error("receive event without a close");
  cover property (huntWr ##[3:4] huntPulse[0]);
  cover property (rxEnd ##[1:3] $rose(rxEvent[0]));
  cover property (odSel_q && !txdOe[0]);
endmodule : scbd_control_chk
bind scbd_control scbd_control_chk chk_u (.*);
`default_nettype wire

// ### scbd_line_peer.sv
`default_nettype none
module scbd_line_peer
  import scbd_pkg::*;
(
  input  wire logic                        sys_clk,
  output logic      [scbd_pkg::CH_W-1:0]   lineCh,
  output logic                             rxClose,
  output logic                             rxCrcErr,
  output logic                             rxOverrun,
  output logic                             rxCarrierLost,
  output logic      [scbd_pkg::DATA_W-1:0] rxByteCount,
  output logic                             txClose,
  output logic                             txUnderrun,
  output logic                             txCtsLost,
  output logic      [scbd_pkg::NCH-1:0]    timerInputPin,
  output logic      [scbd_pkg::NCH-1:0]    txClockPin,
  output logic      [scbd_pkg::NCH-1:0]    txDataIn,
  output logic                             layer1TxIn,
  output logic                             layer1RxIn
);
  logic [7:0] tick = 8'h00;
  always @(posedge sys_clk) tick <= tick + 8'h01;
  assign timerInputPin = {NCH{tick[0]}};
  assign txClockPin = {NCH{tick[1]}};
  assign txDataIn = tick[4:2];
  // between closes the status lines carry the inverse of the last close's values, all ones before the first close
  initial begin
    lineCh = 2'h3;
    {rxClose, txClose} = 2'b00;
    {rxCrcErr, rxOverrun, rxCarrierLost, txUnderrun, txCtsLost} = 5'h1f;
    rxByteCount = 16'hffff;
    {layer1TxIn, layer1RxIn} = 2'b10;
  end
  task automatic closeRx(input logic [1:0] ch, input logic [2:0] err, input logic [15:0] cnt);
    @(posedge sys_clk);
    lineCh <= ch;
    rxClose <= 1'b1;
    {rxCrcErr, rxOverrun, rxCarrierLost} <= err;
    rxByteCount <= cnt;
    @(posedge sys_clk);
    lineCh <= 2'h3;
    rxClose <= 1'b0;
    {rxCrcErr, rxOverrun, rxCarrierLost} <= ~err;
    rxByteCount <= ~cnt;
  endtask : closeRx
  task automatic closeTx(input logic [1:0] ch, input logic [1:0] err);
    @(posedge sys_clk);
    lineCh <= ch;
    txClose <= 1'b1;
    {txUnderrun, txCtsLost} <= err;
    @(posedge sys_clk);
    lineCh <= 2'h3;
    txClose <= 1'b0;
    {txUnderrun, txCtsLost} <= ~err;
  endtask : closeTx
endmodule : scbd_line_peer
`default_nettype wire

// ### test_serial_channel_bd_control.sv
`default_nettype none
module test_serial_channel_bd_control;
  timeunit 1ns;
  timeprecision 1ps;
  import scbd_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] q;
  } scbd_row_s;
  scbd_row_s rows [9] = '{'{12'h882, 16'ha5a5, 16'ha5a5}, '{12'h892, 16'h5a5a, 16'h5a5a},
    '{12'h8a2, 16'hffff, 16'hffff}, '{12'h884, 16'h0002, 16'h0002}, '{12'h894, 16'h8001, 16'h8001},
    '{12'h8a4, 16'h7ffe, 16'h7ffe}, '{12'h8b4, 16'h4321, 16'h4321}, '{12'h8b6, 16'hbeef, 16'h0000},
    '{12'h870, 16'hffff, 16'h0000}};
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData, rxByteCount, rdVal;
  logic [CH_W-1:0]   lineCh;
  logic              rxClose, rxCrcErr, rxOverrun, rxCarrierLost, txClose, txUnderrun, txCtsLost;
  logic              layer1TxIn, layer1RxIn, layer1TxOut, layer1RxToChan, syncStyle;
  logic [NCH-1:0]    timerInputPin, txClockPin, txDataIn, txReady, txExtBuf, rxEmpty, rxExtBuf, rxEvent;
  logic [NCH-1:0]    huntPulse, bcsResetPulse, txClkOut, rxClkOut, txdOut, txdOe;
  int                badCount = 0;
  int                comparisons = 0;
  int                huntSeen [NCH] = '{0, 0, 0};
  int                bcsSeen [NCH] = '{0, 0, 0};
  scbd_control dut_u (.*);
  scbd_line_peer peer_u (.*);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    for (int i = 0; i < NCH; i++) begin
      huntSeen[i] += int'(huntPulse[i] === 1'b1);
      bcsSeen[i] += int'(bcsResetPulse[i] === 1'b1);
    end
  end
  task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chkW
  task automatic chkB(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chkB
  task automatic giveVerdict();
    $display("comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : giveVerdict
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask : rd
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a);
    chkW(rdVal, exp);
  endtask : rdChk
  function automatic logic [ADDR_W-1:0] bdA(input logic [1:0] ch, input logic dir, input logic [2:0] n,
                                            input logic [1:0] w);
    return 12'h400 + {3'h0, ch, dir, n, w, 1'b0};
  endfunction : bdA
  // software side: waits for the flag to drop before the next command
  task automatic cmd(input logic [1:0] op, input logic [1:0] ch);
    int n;
    n = 0;
    wr(CMD_ADDR, {10'h000, ch, 1'b0, op, 1'b1});
    rd(CMD_ADDR);
    chkB(rdVal[0], 1'b1);
    while (rdVal[0] !== 1'b0 && n < 10) begin
      rd(CMD_ADDR);
      n++;
    end
    chkB(rdVal[0], 1'b0);
  endtask : cmd
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    giveVerdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) rdChk(rows[i].a, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdChk(rows[i].a, rows[i].q);
    end
    for (int m = 0; m < 4; m++) begin
      wr(SERIAL_INTERFACE_MODE_ADDR, 16'(m << 12));
      idle(3);
      if (m < 2) chkB(layer1TxOut, m == 0);
      chkB(layer1RxToChan, m >= 2);
    end
    wr(SERIAL_INTERFACE_MODE_ADDR, 16'hc000);
    idle(3);
    chkB(layer1TxOut, 1'b0);
    chkB(syncStyle, 1'b1);
    wr(SERIAL_INTERFACE_MODE_ADDR, 16'h0000);
    idle(3);
    chkB(layer1TxOut, 1'b1);
    chkB(syncStyle, 1'b0);
    for (int c = 0; c < 4; c++) cmd(OP_HUNT, 2'(c));
    cmd(OP_RESET_BCS, 2'h0);
    cmd(OP_RESET_BCS, 2'h1);
    // second command lands while the first still runs and must be dropped
    wr(CMD_ADDR, 16'h0015);
    wr(CMD_ADDR, 16'h0025);
    rdChk(CMD_ADDR, 16'h0014);
    idle(2);
    chkW({4'h0, 4'(huntSeen[0]), 4'(huntSeen[1]), 4'(huntSeen[2])}, 16'h0121);
    chkW({4'h0, 4'(bcsSeen[0]), 4'(bcsSeen[1]), 4'(bcsSeen[2])}, 16'h0100);
    for (int n = 0; n < 8; n++) begin
      wr(bdA(0, DIR_TX, 3'(n), BD_W_CTRL), 16'h0000);
      wr(bdA(0, DIR_RX, 3'(n), BD_W_CTRL), 16'h0000);
    end
    wr(bdA(0, DIR_TX, 3'h0, BD_W_LEN), 16'h0010);
    rdChk(bdA(0, DIR_TX, 3'h0, BD_W_LEN), 16'h0010);
    wr(bdA(0, DIR_TX, 3'h1, BD_W_CTRL), 16'ha000);
    wr(bdA(0, DIR_TX, 3'h0, BD_W_CTRL), 16'hc000);
    idle(3);
    chkB(txReady[0], 1'b1);
    chkB(txExtBuf[0], 1'b1);
    cmd(OP_STOP_TX, 2'h0);
    idle(2);
    chkB(txReady[0], 1'b0);
    cmd(OP_RESTART_TX, 2'h0);
    idle(2);
    chkB(txReady[0], 1'b1);
    peer_u.closeTx(2'h0, 2'b10);
    idle(4);
    rdChk(bdA(0, DIR_TX, 3'h0, BD_W_CTRL), 16'h4002);
    chkB(txReady[0], 1'b1);
    chkB(txExtBuf[0], 1'b0);
    peer_u.closeTx(2'h0, 2'b01);
    idle(4);
    rdChk(bdA(0, DIR_TX, 3'h1, BD_W_CTRL), 16'h2001);
    chkB(txReady[0], 1'b0);
    wr(bdA(0, DIR_TX, 3'h0, BD_W_CTRL), 16'h8000);
    idle(3);
    chkB(txReady[0], 1'b1);
    wr(bdA(0, DIR_RX, 3'h0, BD_W_CTRL), 16'h9000);
    wr(bdA(0, DIR_RX, 3'h1, BD_W_CTRL), 16'he000);
    idle(3);
    chkB(rxEmpty[0], 1'b1);
    peer_u.closeRx(2'h0, 3'b111, 16'h0123);
    idle(4);
    rdChk(bdA(0, DIR_RX, 3'h0, BD_W_CTRL), 16'h1006);
    rdChk(bdA(0, DIR_RX, 3'h0, BD_W_LEN), 16'h0123);
    rdChk(EVENT_BASE, 16'h0001);
    chkB(rxExtBuf[0], 1'b1);
    wr(EVENT_BASE, 16'h0001);
    wr(MODE_CFG_BASE, 16'h8000);
    rdChk(EVENT_BASE, 16'h0000);
    peer_u.closeRx(2'h0, 3'b001, 16'hffff);
    idle(4);
    rdChk(bdA(0, DIR_RX, 3'h1, BD_W_CTRL), 16'h6001);
    rdChk(EVENT_BASE, 16'h0000);
    chkB(rxEmpty[0], 1'b0);
    peer_u.closeRx(2'h0, 3'b110, 16'h0042);
    idle(4);
    rdChk(bdA(0, DIR_RX, 3'h0, BD_W_LEN), 16'h0123);
    wr(12'h8a2, 16'h4002);
    idle(4100);
    rdVal[0] = rxClkOut[2];
    idle(4);
    chkB(rxClkOut[2], !rdVal[0]);
    giveVerdict();
  end
endmodule : test_serial_channel_bd_control
`default_nettype wire
